// ### logic/scmp_defs.svh
// Constants shared by the serial command mode parser files.
`ifndef SCMP_DEFS_SVH
`define SCMP_DEFS_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SCMP_CLK_HZ 40000000
`define SCMP_MS_PER_S 1000
`define SCMP_CYC_PER_MS (`SCMP_CLK_HZ / `SCMP_MS_PER_S)
`define SCMP_UNIT_MS 16'h0064
`define SCMP_MS_SAT 16'hFFFF

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define SCMP_OFF_CTRL 8'h00
`define SCMP_OFF_STATUS 8'h04
`define SCMP_OFF_FW_REV 8'h08
`define SCMP_OFF_HW_REV 8'h0C
`define SCMP_OFF_SUPPLY 8'h10
`define SCMP_OFF_TIMEOUT 8'h14
`define SCMP_OFF_GUARD 8'h18
`define SCMP_OFF_ESC 8'h1C
`define SCMP_OFF_NETNUM 8'h20
`define SCMP_OFF_DISCWIN 8'h24
`define SCMP_OFF_DEST_HI 8'h28
`define SCMP_OFF_DEST_LO 8'h2C

// ----------------------------------------------------------------------------
// Control bits, ranges and reset values
// ----------------------------------------------------------------------------
`define SCMP_CTRL_EXIT 0
`define SCMP_CTRL_NAME 1
`define SCMP_CTRL_RESOLVE 2
`define SCMP_TIMEOUT_DEF 16'h0064
`define SCMP_TIMEOUT_MIN 16'h0002
`define SCMP_TIMEOUT_MAX 16'h028F
`define SCMP_GUARD_DEF 16'h03E8
`define SCMP_GUARD_MIN 16'h0001
`define SCMP_GUARD_MAX 16'h0CE4
`define SCMP_ESC_DEF 8'h2B
`define SCMP_ESC_COUNT 2'd3
`define SCMP_NET_DEF 16'h7FFF
`define SCMP_NET_MAX 16'h7FFF
`define SCMP_WIN_DEF 16'h003C
`define SCMP_WIN_MAX 16'h00FC
`define SCMP_FW_REV_DEF 16'h0101
`define SCMP_HW_REV_DEF 16'h0202

// ----------------------------------------------------------------------------
// Node name string
// ----------------------------------------------------------------------------
`define SCMP_NAME_MAX 5'd20
`define SCMP_NAME_BITS 160
`define SCMP_CHAR_CR 8'h0D
`define SCMP_CHAR_SPACE 8'h20
`define SCMP_CHAR_LAST 8'h7E
`define SCMP_NAME_DEF 160'h20
`define SCMP_NAME_LEN_DEF 5'd1

`endif

// ### logic/scmp_pkg.sv
// Types shared by the serial command mode parser files.
`include "scmp_defs.svh"
package scmp_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_NAME, ST_KEY, ST_DISC, ST_ACK_EXIT} scmp_state_t;
  typedef enum logic [1:0] {RESP_NONE, RESP_OK, RESP_ERR} scmp_resp_t;
  typedef logic [`SCMP_NAME_BITS-1:0] scmp_name_t;
endpackage

// ### logic/scmp_ms_timer.sv
// Millisecond counter that restarts on request and saturates.
`include "scmp_defs.svh"
module scmp_ms_timer #(
  parameter int unsigned CYC_PER_MS = `SCMP_CYC_PER_MS
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clear,
  output logic [15:0] ms_count
);
  logic [15:0] pre_q;
  logic [15:0] ms_q;
  wire pre_wrap = (pre_q == 16'(CYC_PER_MS - 1));

  // Clearing also restarts the prescaler so a count of N means at least N ms.
  always_ff @(posedge ref_clk) begin
    if (!rst_n || clear) begin
      pre_q <= 16'h0000;
      ms_q <= 16'h0000;
    end else begin
      pre_q <= pre_wrap ? 16'h0000 : pre_q + 16'h0001;
      if (pre_wrap && ms_q != `SCMP_MS_SAT) begin
        ms_q <= ms_q + 16'h0001;
      end
    end
  end

  assign ms_count = ms_q;
endmodule

// ### logic/scmp_name_store.sv
// Collects a printable name string from serial bytes and commits it whole.
`include "scmp_defs.svh"
module scmp_name_store
  import scmp_pkg::*;
#(
  parameter scmp_name_t DEF_NAME = '0,
  parameter logic [4:0] DEF_LEN = 5'd0
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic in_valid,
  input wire logic [7:0] in_byte,
  output logic busy,
  output logic done,
  output logic bad,
  output scmp_name_t name,
  output logic [4:0] len
);
  logic busy_q;
  logic done_q;
  logic bad_q;
  scmp_name_t sh_q;
  logic [4:0] sl_q;
  scmp_name_t name_q;
  logic [4:0] len_q;

  wire is_cr = (in_byte == `SCMP_CHAR_CR);
  wire printable = (in_byte >= `SCMP_CHAR_SPACE) && (in_byte <= `SCMP_CHAR_LAST);
  wire lead_space = (sl_q == 5'd0) && (in_byte == `SCMP_CHAR_SPACE);
  wire [4:0] sl_inc = sl_q + 5'd1;
  wire scmp_name_t sh_ins = sh_q | (scmp_name_t'(in_byte) << {sl_q, 3'b000});

  // A bad string leaves the stored name untouched.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      bad_q <= 1'b0;
      sh_q <= '0;
      sl_q <= 5'd0;
      name_q <= DEF_NAME;
      len_q <= DEF_LEN;
    end else begin
      done_q <= 1'b0;
      bad_q <= 1'b0;
      if (start) begin
        busy_q <= 1'b1;
        sh_q <= '0;
        sl_q <= 5'd0;
      end else if (busy_q && in_valid) begin
        if (is_cr) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
          name_q <= sh_q;
          len_q <= sl_q;
        end else if (!printable || lead_space) begin
          busy_q <= 1'b0;
          bad_q <= 1'b1;
        end else if (sl_inc == `SCMP_NAME_MAX) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
          name_q <= sh_ins;
          len_q <= sl_inc;
        end else begin
          sh_q <= sh_ins;
          sl_q <= sl_inc;
        end
      end
    end
  end

  assign busy = busy_q;
  assign done = done_q;
  assign bad = bad_q;
  assign name = name_q;
  assign len = len_q;
endmodule

// ### logic/scmp_top.sv
// Serial command mode parser: entry sequence, command mode and settings.
// Notes on behaviour
// - Firmware revision reads as fixed 16-bit value.
// - Hardware revision reads as fixed 16-bit value.
// - Supply reading is raw; host scales to mV.
// - Inactivity in ST_CMD returns to idle; name and key entry have no timeout.
// - Exit command leaves command mode immediately.
// - Guard silence required before and after escapes.
// - Escape character configurable, default plus sign.
// - Framed escape sequence enters command mode.
// - Network number held; only matching nodes accepted.
// - Discovery window in 100 ms units, bounded.
// - Node name up to 20 printable bytes.
// - Name starting with space is rejected.
// - Name entry ends on CR or full.
// - Lookup hit loads 64-bit destination address.
// - Lookup hit sends OK CR, leaves command mode.
// - Lookup timeout or blank name gives ERROR.
`include "scmp_defs.svh"
module scmp_top
  import scmp_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `SCMP_CYC_PER_MS,
  parameter logic [15:0] FW_REV = `SCMP_FW_REV_DEF,
  parameter logic [15:0] HW_REV = `SCMP_HW_REV_DEF
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic data_valid,
  output logic [7:0] data_byte,
  input wire logic tx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic [15:0] supply_raw,
  output logic disc_start,
  input wire logic disc_rsp_valid,
  input wire logic [15:0] disc_rsp_net,
  input wire scmp_pkg::scmp_name_t disc_rsp_name,
  input wire logic [4:0] disc_rsp_len,
  input wire logic [63:0] disc_rsp_addr,
  output logic cmd_mode,
  output logic [14:0] network_number,
  output scmp_pkg::scmp_name_t node_name_string,
  output logic [4:0] node_name_len
);
  import scmp_pkg::*;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] nw, input logic [3:0] sel);
    merge16 = {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
  endfunction

  function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  function automatic logic [7:0] resp_char(input scmp_resp_t r, input logic [2:0] i);
    logic [47:0] s;
    s = (r == RESP_OK) ? {24'h000000, 8'h4F, 8'h4B, `SCMP_CHAR_CR} : {8'h45, 8'h52, 8'h52, 8'h4F, 8'h52, `SCMP_CHAR_CR};
    resp_char = (r == RESP_OK) ? s[8*(2-i) +: 8] : s[8*(5-i) +: 8];
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  scmp_state_t state_q;
  logic [1:0] esc_cnt_q;
  logic restart_q;
  logic last_err_q;
  logic [15:0] timeout_q;
  logic [15:0] guard_q;
  logic [7:0] esc_q;
  logic [14:0] net_q;
  logic [15:0] win_q;
  logic [31:0] dest_hi_q;
  logic [31:0] dest_lo_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic data_valid_q;
  logic [7:0] data_byte_q;
  scmp_resp_t resp_q;
  logic [2:0] ridx_q;
  logic tx_valid_q;
  logic [7:0] tx_data_q;
  logic disc_start_q;
  logic send_ok;
  logic send_err;

  logic [15:0] sil_ms;
  logic [15:0] act_ms;
  logic name_busy, name_done, name_bad;
  logic key_busy, key_done, key_bad;
  scmp_name_t key_name;
  logic [4:0] key_len;

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  wire bus_req = wb_cyc_i && wb_stb_i && !ack_q;
  wire wr = bus_req && wb_we_i;
  wire in_cmd = (state_q == ST_CMD);
  wire ctrl_wr = wr && (wb_adr_i == `SCMP_OFF_CTRL) && in_cmd;
  wire [15:0] wdat16 = merge16(16'h0000, wb_dat_i, wb_sel_i);
  wire valid_cmd = wr && in_cmd;
  wire do_exit = ctrl_wr && wb_sel_i[0] && wb_dat_i[`SCMP_CTRL_EXIT];
  wire do_name = ctrl_wr && wb_sel_i[0] && wb_dat_i[`SCMP_CTRL_NAME] && !do_exit;
  wire do_resolve = ctrl_wr && wb_sel_i[0] && wb_dat_i[`SCMP_CTRL_RESOLVE] && !do_exit && !do_name;
  wire sender_busy = (resp_q != RESP_NONE);
  wire [31:0] status_w = {16'h0000, 3'b000, node_name_len, last_err_q, sender_busy, esc_cnt_q, 1'b0, state_q};
  wire [31:0] rd_data =
    (wb_adr_i == `SCMP_OFF_STATUS) ? status_w :
    (wb_adr_i == `SCMP_OFF_FW_REV) ? {16'h0000, FW_REV} :
    (wb_adr_i == `SCMP_OFF_HW_REV) ? {16'h0000, HW_REV} :
    (wb_adr_i == `SCMP_OFF_SUPPLY) ? {16'h0000, supply_raw} :
    (wb_adr_i == `SCMP_OFF_TIMEOUT) ? {16'h0000, timeout_q} :
    (wb_adr_i == `SCMP_OFF_GUARD) ? {16'h0000, guard_q} :
    (wb_adr_i == `SCMP_OFF_ESC) ? {24'h000000, esc_q} :
    (wb_adr_i == `SCMP_OFF_NETNUM) ? {17'h00000, net_q} :
    (wb_adr_i == `SCMP_OFF_DISCWIN) ? {16'h0000, win_q} :
    (wb_adr_i == `SCMP_OFF_DEST_HI) ? dest_hi_q :
    (wb_adr_i == `SCMP_OFF_DEST_LO) ? dest_lo_q : 32'h00000000;

  // --------------------------------------------------------------------------
  // Timing terms
  // --------------------------------------------------------------------------
  wire guard_met = (sil_ms >= guard_q);
  wire esc_hit = rx_valid && (rx_data == esc_q);
  wire [15:0] timeout_ms = 16'(timeout_q * `SCMP_UNIT_MS);
  wire [15:0] win_ms = 16'(win_q * `SCMP_UNIT_MS);
  wire idle_expired = (act_ms >= timeout_ms) && !restart_q;
  wire disc_expired = (act_ms >= win_ms) && !restart_q;
  wire disc_match = disc_rsp_valid && (disc_rsp_net == {1'b0, net_q}) &&
    (disc_rsp_len == key_len) && (disc_rsp_name == key_name);
  wire resp_last = (resp_q == RESP_OK) ? (ridx_q == 3'd2) : (ridx_q == 3'd5);

  scmp_ms_timer #(.CYC_PER_MS(MS_CYCLES)) u_silence (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clear(rx_valid),
    .ms_count(sil_ms)
  );

  scmp_ms_timer #(.CYC_PER_MS(MS_CYCLES)) u_activity (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clear(restart_q),
    .ms_count(act_ms)
  );

  scmp_name_store #(.DEF_NAME(`SCMP_NAME_DEF), .DEF_LEN(`SCMP_NAME_LEN_DEF)) u_node_name (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .start(do_name),
    .in_valid(rx_valid && state_q == ST_NAME),
    .in_byte(rx_data),
    .busy(name_busy),
    .done(name_done),
    .bad(name_bad),
    .name(node_name_string),
    .len(node_name_len)
  );

  scmp_name_store #(.DEF_NAME('0), .DEF_LEN(5'd0)) u_lookup_key (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .start(do_resolve),
    .in_valid(rx_valid && state_q == ST_KEY),
    .in_byte(rx_data),
    .busy(key_busy),
    .done(key_done),
    .bad(key_bad),
    .name(key_name),
    .len(key_len)
  );

  // --------------------------------------------------------------------------
  // Mode sequencer
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      esc_cnt_q <= 2'd0;
      restart_q <= 1'b1;
      disc_start_q <= 1'b0;
      send_ok <= 1'b0;
      send_err <= 1'b0;
      dest_hi_q <= 32'h00000000;
      dest_lo_q <= 32'h00000000;
    end else begin
      restart_q <= valid_cmd;
      disc_start_q <= 1'b0;
      send_ok <= 1'b0;
      send_err <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (rx_valid) begin
            // Anything but an escape, a first escape without silence, or a fourth escape cancels.
            if (esc_hit && ((esc_cnt_q == 2'd0 && guard_met) || (esc_cnt_q != 2'd0 && esc_cnt_q != `SCMP_ESC_COUNT))) begin
              esc_cnt_q <= esc_cnt_q + 2'd1;
            end else begin
              esc_cnt_q <= 2'd0;
            end
          end else if (esc_cnt_q == `SCMP_ESC_COUNT && guard_met) begin
            esc_cnt_q <= 2'd0;
            state_q <= ST_CMD;
            restart_q <= 1'b1;
          end
        end
        ST_CMD: begin
          if (do_exit) begin
            state_q <= ST_IDLE;
          end else if (do_name) begin
            state_q <= ST_NAME;
          end else if (do_resolve) begin
            state_q <= ST_KEY;
          end else if (idle_expired) begin
            state_q <= ST_IDLE;
          end
        end
        ST_NAME: begin
          if (name_done || name_bad) begin
            state_q <= ST_CMD;
            restart_q <= 1'b1;
            send_ok <= name_done;
            send_err <= name_bad;
          end
        end
        ST_KEY: begin
          if (key_bad || (key_done && key_len == 5'd0)) begin
            state_q <= ST_CMD;
            restart_q <= 1'b1;
            send_err <= 1'b1;
          end else if (key_done) begin
            state_q <= ST_DISC;
            restart_q <= 1'b1;
            disc_start_q <= 1'b1;
          end
        end
        ST_DISC: begin
          if (disc_match) begin
            dest_hi_q <= disc_rsp_addr[63:32];
            dest_lo_q <= disc_rsp_addr[31:0];
            send_ok <= 1'b1;
            state_q <= ST_ACK_EXIT;
          end else if (disc_expired) begin
            send_err <= 1'b1;
            state_q <= ST_CMD;
            restart_q <= 1'b1;
          end
        end
        ST_ACK_EXIT: begin
          if (!send_ok && !sender_busy) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Settings registers and bus answer
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      timeout_q <= `SCMP_TIMEOUT_DEF;
      guard_q <= `SCMP_GUARD_DEF;
      esc_q <= `SCMP_ESC_DEF;
      net_q <= 15'(`SCMP_NET_DEF);
      win_q <= `SCMP_WIN_DEF;
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ack_q <= bus_req;
      if (bus_req) begin
        rdat_q <= rd_data;
      end
      // Out-of-range values are dropped so the settings stay legal.
      if (valid_cmd && wb_adr_i == `SCMP_OFF_TIMEOUT && in_range(wdat16, `SCMP_TIMEOUT_MIN, `SCMP_TIMEOUT_MAX)) begin
        timeout_q <= wdat16;
      end
      if (valid_cmd && wb_adr_i == `SCMP_OFF_GUARD && in_range(wdat16, `SCMP_GUARD_MIN, `SCMP_GUARD_MAX)) begin
        guard_q <= wdat16;
      end
      if (valid_cmd && wb_adr_i == `SCMP_OFF_ESC && wb_sel_i[0]) begin
        esc_q <= wb_dat_i[7:0];
      end
      if (valid_cmd && wb_adr_i == `SCMP_OFF_NETNUM && wdat16 <= `SCMP_NET_MAX) begin
        net_q <= wdat16[14:0];
      end
      if (valid_cmd && wb_adr_i == `SCMP_OFF_DISCWIN && wdat16 <= `SCMP_WIN_MAX) begin
        win_q <= wdat16;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Serial answer and idle-mode data path
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      resp_q <= RESP_NONE;
      ridx_q <= 3'd0;
      tx_valid_q <= 1'b0;
      tx_data_q <= 8'h00;
      last_err_q <= 1'b0;
      data_valid_q <= 1'b0;
      data_byte_q <= 8'h00;
    end else begin
      data_valid_q <= rx_valid && state_q == ST_IDLE;
      data_byte_q <= rx_data;
      if (send_ok || send_err) begin
        resp_q <= send_ok ? RESP_OK : RESP_ERR;
        ridx_q <= 3'd0;
        tx_valid_q <= 1'b1;
        tx_data_q <= resp_char(send_ok ? RESP_OK : RESP_ERR, 3'd0);
        last_err_q <= send_err;
      end else if (tx_valid_q && tx_ready) begin
        if (resp_last) begin
          resp_q <= RESP_NONE;
          tx_valid_q <= 1'b0;
        end else begin
          ridx_q <= ridx_q + 3'd1;
          tx_data_q <= resp_char(resp_q, ridx_q + 3'd1);
        end
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign data_valid = data_valid_q;
  assign data_byte = data_byte_q;
  assign tx_valid = tx_valid_q;
  assign tx_data = tx_data_q;
  assign disc_start = disc_start_q;
  assign cmd_mode = (state_q != ST_IDLE);
  assign network_number = net_q;
endmodule

// ### bench/scmp_assertions.sv
// Port-level assertions for the serial command mode parser.
`include "scmp_defs.svh"
module scmp_assertions #(
  parameter int unsigned MS_CYCLES = 4,
  parameter logic [15:0] FW_REV = 16'h0000,
  parameter logic [15:0] HW_REV = 16'h0000
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic data_valid,
  input wire logic [7:0] data_byte,
  input wire logic tx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic [15:0] supply_raw,
  input wire logic disc_start,
  input wire logic cmd_mode,
  input wire logic [14:0] network_number
);
  // Cycles since the last serial byte; saturates so long idle spans stay legal.
  logic [15:0] quiet_q;
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire rd_ack = wb_ack_o && !wb_we_i;
  always_ff @(posedge ref_clk) begin
    if (!rst_n || rx_valid) begin
      quiet_q <= 16'h0000;
    end else if (quiet_q != 16'hFFFF) begin
      quiet_q <= quiet_q + 16'h0001;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_ack_next; req |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
  property p_fw; rd_ack && wb_adr_i == `SCMP_OFF_FW_REV |-> wb_dat_o[15:0] == FW_REV; endproperty
  a_fw: assert property (p_fw) else $error("fw rev");
  property p_hw; rd_ack && wb_adr_i == `SCMP_OFF_HW_REV |-> wb_dat_o[15:0] == HW_REV; endproperty
  a_hw: assert property (p_hw) else $error("hw rev");
  property p_supply;
    rd_ack && wb_adr_i == `SCMP_OFF_SUPPLY |-> wb_dat_o[15:0] == $past(supply_raw);
  endproperty
  a_supply: assert property (p_supply) else $error("supply");
  property p_exit;
    req && wb_we_i && wb_adr_i == `SCMP_OFF_CTRL && wb_sel_i[0] && wb_dat_i[0] && cmd_mode |-> ##[1:4] !cmd_mode;
  endproperty
  a_exit: assert property (p_exit) else $error("no exit");
  property p_forward; rx_valid && !cmd_mode |=> data_valid && data_byte == $past(rx_data); endproperty
  a_forward: assert property (p_forward) else $error("no forward");
  property p_net_hold; !(req && wb_we_i) |=> $stable(network_number); endproperty
  a_net_hold: assert property (p_net_hold) else $error("net changed");
  property p_tx_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx dropped");
  property p_entry_quiet; $rose(cmd_mode) |-> quiet_q >= 16'(MS_CYCLES - 1); endproperty
  a_entry_quiet: assert property (p_entry_quiet) else $error("no guard");
  property p_disc; disc_start |-> cmd_mode ##1 !disc_start; endproperty
  a_disc: assert property (p_disc) else $error("bad disc start");
endmodule

// ### bench/scmp_host_model.sv
// Host microcontroller on the serial side: sends bytes, accepts replies slowly.
module scmp_host_model (
  input wire logic ref_clk,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic rx_valid = 1'b0,
  output logic [7:0] rx_data = 8'hA5,
  output logic tx_ready = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] got[$];
  logic [1:0] ph_q = 2'h0;
  // Ready two cycles of four, so some reply bytes must wait.
  always @(posedge ref_clk) begin
    ph_q <= ph_q + 2'h1;
    tx_ready <= ph_q[1];
    if (tx_valid && tx_ready) got.push_back(tx_data);
  end
  // The released line shows the inverse so a stale byte cannot pass.
  task automatic send(input logic [7:0] b);
    @(posedge ref_clk);
    rx_valid <= 1'b1;
    rx_data <= b;
    @(posedge ref_clk);
    rx_valid <= 1'b0;
    rx_data <= ~b;
  endtask
  task automatic quiet(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
endmodule

// ### bench/testbench.sv
// Self-checking bench for the serial command mode parser.
`include "scmp_defs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import scmp_pkg::*;
  localparam logic [15:0] FW = 16'h0A51; // Arbitrary revision value.
  localparam logic [15:0] HW = 16'h0B62; // Arbitrary revision value.
  localparam logic [63:0] AD = 64'h1122334455667788;
  typedef struct packed {logic we; logic [7:0] adr; logic [15:0] dat; logic [15:0] exp;} scmp_row_t;
  logic ref_clk = 1'b0, rst_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, disc_rsp_valid = 1'b0;
  logic wb_ack_o, data_valid, tx_ready, tx_valid, disc_start, cmd_mode, rx_valid;
  logic [7:0] wb_adr_i = 8'h00, rx_data, data_byte, tx_data;
  logic [3:0] wb_sel_i = 4'h3;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic [15:0] supply_raw = 16'h08FE, disc_rsp_net = 16'h0;
  logic [4:0] disc_rsp_len = 5'd2, node_name_len;
  logic [63:0] disc_rsp_addr = 64'h0;
  logic [14:0] network_number;
  scmp_name_t disc_rsp_name = 160'h4241, node_name_string, name_e;
  int error_cnt = 0;
  int checks = 0;
  scmp_row_t rows [19] = '{
    '{0, 8'h08, 0, FW}, '{0, 8'h0C, 0, HW}, '{0, 8'h10, 0, 16'h08FE},
    '{0, 8'h30, 0, 0}, '{0, 8'h14, 0, 16'h0064}, '{0, 8'h18, 0, 16'h03E8},
    '{0, 8'h1C, 0, 16'h002B}, '{0, 8'h20, 0, 16'h7FFF}, '{0, 8'h24, 0, 16'h003C},
    '{1, 8'h14, 16'h0001, 16'h0064}, '{1, 8'h14, 16'h0290, 16'h0064}, '{1, 8'h14, 16'h0002, 16'h0002},
    '{1, 8'h18, 16'h0CE5, 16'h03E8}, '{1, 8'h18, 16'h0002, 16'h0002}, '{1, 8'h1C, 16'h007E, 16'h007E},
    '{1, 8'h20, 16'h8000, 16'h7FFF}, '{1, 8'h20, 16'h1234, 16'h1234},
    '{1, 8'h24, 16'h00FD, 16'h003C}, '{1, 8'h24, 16'h0001, 16'h0001}};
  always #12.5 ref_clk = ~ref_clk;
  scmp_top #(.MS_CYCLES(4), .FW_REV(FW), .HW_REV(HW)) i_dut (.*);
  scmp_host_model i_host (.ref_clk, .tx_valid, .tx_data, .rx_valid, .rx_data, .tx_ready);
  // ------------
  // Shared tasks
  // ------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [159:0] e, g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic hang(input string nm);
    error_cnt++;
    $display("ERROR %s expected answer seen timeout", nm);
    test_done();
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [15:0] d, output logic [31:0] q);
    int n = 0;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {16'h0, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) hang("wb_ack_o");
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 16'h0, q);
    chk($sformatf("reg %h", a), e, q);
  endtask
  task automatic send_str(input string s);
    foreach (s[i]) i_host.send(s[i]);
  endtask
  task automatic enter(input int g, input logic [7:0] e);
    i_host.quiet(g);
    repeat (3) i_host.send(e);
    i_host.quiet(g);
    chk("cmd_mode entry", 1, cmd_mode);
  endtask
  task automatic expect_tx(input string s);
    int n = 0;
    while (i_host.got.size() < s.len() && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    foreach (s[i]) chk("tx_data", s[i], i_host.got[i]);
    i_host.got.delete();
  endtask
  task automatic lookup(input string key);
    int n = 0;
    wr(8'h00, 16'h0004);
    send_str(key);
    while (disc_start !== 1'b1 && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 100) hang("disc_start");
  endtask
  task automatic answer(input logic [15:0] net, input logic [63:0] ad);
    @(posedge ref_clk);
    disc_rsp_valid <= 1'b1;
    disc_rsp_net <= net;
    disc_rsp_addr <= ad;
    @(posedge ref_clk);
    disc_rsp_valid <= 1'b0;
    disc_rsp_net <= ~net;
    disc_rsp_addr <= ~ad;
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    chk("network_number", 15'h7FFF, network_number);
    chk("node_name_string", 160'h20, node_name_string);
    chk("node_name_len", 1, node_name_len);
    enter(4010, 8'h2B);
    foreach (rows[i]) begin
      if (rows[i].we) wr(rows[i].adr, rows[i].dat);
      rdc(rows[i].adr, rows[i].exp);
    end
    chk("network_number", 15'h1234, network_number);
    supply_raw <= 16'h0123;
    rdc(8'h10, 32'h0123);
    wb_sel_i <= 4'h2;
    wr(8'h20, 16'h5678);
    wb_sel_i <= 4'h3;
    rdc(8'h20, 32'h5600);
    wr(8'h20, 16'h1234);
    $display("test registers done");
    wr(8'h00, 16'h0001);
    repeat (3) @(posedge ref_clk);
    chk("cmd_mode exit", 0, cmd_mode);
    wr(8'h20, 16'h0055);
    rdc(8'h20, 16'h1234);
    i_host.quiet(20);
    repeat (3) i_host.send(8'h7E);
    i_host.send(8'h61);
    i_host.quiet(40);
    chk("cmd_mode cancel", 0, cmd_mode);
    enter(10, 8'h7E);
    $display("test entry done");
    wr(8'h00, 16'h0002);
    i_host.send(8'h20);
    expect_tx("ERROR\015");
    wr(8'h00, 16'h0002);
    send_str("AB\015");
    expect_tx("OK\015");
    chk("node_name_string", 160'h4241, node_name_string);
    wr(8'h00, 16'h0002);
    name_e = '0;
    for (int i = 0; i < 20; i++) begin
      i_host.send(8'h41 + 8'(i));
      name_e[8*i +: 8] = 8'h41 + 8'(i);
    end
    expect_tx("OK\015");
    chk("node_name_string", name_e, node_name_string);
    chk("node_name_len", 20, node_name_len);
    $display("test name done");
    wr(8'h00, 16'h0004);
    i_host.send(8'h0D);
    expect_tx("ERROR\015");
    lookup("AB\015");
    i_host.quiet(300);
    chk("early reply", 0, i_host.got.size());
    expect_tx("ERROR\015");
    chk("cmd_mode after miss", 1, cmd_mode);
    lookup("AB\015");
    answer(16'h0001, ~AD);
    disc_rsp_len <= 5'd3;
    answer(16'h1234, ~AD);
    disc_rsp_len <= 5'd2;
    answer(16'h1234, AD);
    expect_tx("OK\015");
    repeat (3) @(posedge ref_clk);
    chk("cmd_mode after hit", 0, cmd_mode);
    rdc(8'h28, AD[63:32]);
    rdc(8'h2C, AD[31:0]);
    $display("test lookup done");
    enter(10, 8'h7E);
    i_host.quiet(600);
    chk("cmd_mode before timeout", 1, cmd_mode);
    i_host.quiet(400);
    chk("cmd_mode after timeout", 0, cmd_mode);
    $display("test inactivity done");
    test_done();
  end
endmodule
bind scmp_top scmp_assertions #(.MS_CYCLES(MS_CYCLES), .FW_REV(FW_REV), .HW_REV(HW_REV)) i_chk (.*);
